// >>> hw/sadc_port.sv
/*
 * Register port and conversion sequencer of a 12-bit, 32-channel software-triggered converter.
 * Assumes a 16-location I/O window already selected by the caller (io_sel), host strobes that
 * are synchronous single-cycle pulses on core_clk, and an external converter that returns a
 * done pulse with 12-bit data.
 * Holds the channel and gain latches, the one-shot trigger, the 12-bit result and its
 * pending flag, and answers host reads from registered read data.
 * The converter's done and data lines are asynchronous to core_clk and pass two flops here;
 * data must stay steady while done is high, and done must last at least one core_clk cycle.
 * A conversion that never reports done is closed after CONV_CYCLES with whatever data stands.
 */
// What this block does
// - Decodes sixteen byte locations by offset from the selected base.
// - Holds each finished conversion as a twelve-bit result, bit 11 highest.
// - Offset four reads result bits 7 to 0.
// - Offset five reads result 11..8, pending flag on bit 4, zeros above.
// - Pending flag is one until a conversion completes, then zero.
// - Reading offset four sets the pending flag back to one.
// - Write at offset ten loads channel from bits 4..0, switches mux at once.
// - Channel is plain binary, selecting inputs 0 through 31.
// - Write at offset nine loads gain code bits 2..0: x1,x2,x4,x8,x16.
// - One gain setting applies to every converted channel.
// - A write at offset twelve while idle starts one conversion; data ignored.
// - No start source exists other than the trigger write.
// - Converter starts on the rising edge of the internal trigger pulse.
`timescale 1ns/100ps
`include "sadc_defs.svh"

module sadc_port #(
	parameter int CONV_CYCLES = `SADC_CONV_CYCLES
) (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Host I/O access
	input wire sadc_pkg::sadc_io_req_t io_req,
	input wire logic io_sel,
	output logic [7:0] io_rdata,
	// Converter side
	input wire logic conv_done,
	input wire logic [11:0] conv_data,
	output logic [4:0] mux_channel,
	output sadc_pkg::sadc_gain_t gain_onehot,
	output logic conv_start,
	output logic conv_busy
);

	// Counter is 16 bits wide and must reload to at least one
	if (CONV_CYCLES < 1) begin : g_conv_cycles_low
		$error("CONV_CYCLES must be at least one");
	end
	if (CONV_CYCLES > 65535) begin : g_conv_cycles_high
		$error("CONV_CYCLES does not fit the 16-bit counter");
	end

	// Timeout counter reload and last count
	localparam logic [15:0] CNT_RELOAD = 16'(CONV_CYCLES);
	localparam logic [15:0] CNT_LAST = 16'h0001;

	////////////////////////////////////////////////////////////////////////////////
	// Gain decode
	function automatic sadc_pkg::sadc_gain_t gain_decode(input logic [2:0] code);
		sadc_pkg::sadc_gain_t g;
		g = 5'h00;
		if (code >= `SADC_GAIN_X16_CODE) begin
			g[4] = 1'b1;
		end else begin
			g[code[1:0]] = 1'b1;
		end
		return g;
	endfunction

	// True when a strobe is taken at the given window offset
	function automatic logic hit_at(input logic strobe, input logic [3:0] ofs,
			input logic [3:0] want);
		return strobe && (ofs == want);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State image
	typedef struct packed {
		sadc_pkg::sadc_state_t st;
		logic [15:0] cnt;
		logic [11:0] result;
		logic pending;
		logic [4:0] channel;
		logic [2:0] gain;
		logic [7:0] rdata;
		logic start;
		logic [4:0] mux;
		sadc_pkg::sadc_gain_t gain_oh;
		logic busy;
		logic done_s1;
		logic done_s2;
		logic [11:0] data_s1;
		logic [11:0] data_s2;
	} sadc_state_regs_t;

	// Reset image: pending set because no result is held yet
	localparam sadc_state_regs_t RESET_STATE = '{
		st: sadc_pkg::SADC_IDLE,
		cnt: 16'h0000,
		result: `SADC_RESET_RESULT,
		pending: 1'b1,
		channel: `SADC_RESET_CHANNEL,
		gain: `SADC_RESET_GAIN,
		rdata: 8'h00,
		start: 1'b0,
		mux: `SADC_RESET_CHANNEL,
		gain_oh: `SADC_RESET_GAIN_OH,
		busy: 1'b0,
		done_s1: 1'b0,
		done_s2: 1'b0,
		data_s1: `SADC_RESET_RESULT,
		data_s2: `SADC_RESET_RESULT
	};

	sadc_state_regs_t s_reg;
	sadc_state_regs_t s_next;
	// Strobes qualified by the window select
	logic rd_hit;
	logic wr_hit;

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_next = s_reg;
		rd_hit = io_sel && io_req.rd;
		wr_hit = io_sel && io_req.wr;
		s_next.start = 1'b0;
		s_next.rdata = 8'h00;

		// Converter pins cross into core_clk through two flops each
		s_next.done_s1 = conv_done;
		s_next.done_s2 = s_reg.done_s1;
		s_next.data_s1 = conv_data;
		s_next.data_s2 = s_reg.data_s1;

		if (rd_hit) begin
			unique case (io_req.ofs)
				`SADC_OFS_RESULT_LOW: begin
					s_next.rdata = s_reg.result[7:0];
				end
				`SADC_OFS_RESULT_HIGH: begin
					s_next.rdata = {3'h0, s_reg.pending, s_reg.result[11:8]};
				end
				default: begin
					s_next.rdata = 8'h00;
				end
			endcase
		end
		if (wr_hit) begin
			unique case (io_req.ofs)
				`SADC_OFS_GAIN_SELECT: begin
					s_next.gain = io_req.wdata[`SADC_GAIN_MSB:0];
				end
				`SADC_OFS_CHANNEL_SELECT: begin
					s_next.channel = io_req.wdata[`SADC_CHANNEL_MSB:0];
				end
				default: begin
				end
			endcase
		end
		unique case (s_reg.st)
			sadc_pkg::SADC_IDLE: begin
				if (hit_at(wr_hit, io_req.ofs, `SADC_OFS_CONV_TRIGGER)) begin
					s_next.st = sadc_pkg::SADC_START;
					s_next.start = 1'b1;
					s_next.pending = 1'b1;
					s_next.cnt = CNT_RELOAD;
				end
			end
			// Trigger writes are ignored until the sequencer is idle again
			sadc_pkg::SADC_START: begin
				s_next.st = sadc_pkg::SADC_BUSY;
			end
			sadc_pkg::SADC_BUSY: begin
				if (s_reg.done_s2 || s_reg.cnt == CNT_LAST) begin
					// A missing done pulse still closes the cycle at the timeout
					s_next.result = s_reg.data_s2;
					s_next.pending = 1'b0;
					s_next.st = sadc_pkg::SADC_IDLE;
				end else begin
					s_next.cnt = s_reg.cnt - 16'h0001;
				end
			end
			default: begin
				s_next.st = sadc_pkg::SADC_IDLE;
			end
		endcase
		// Completion in the same cycle as the low-byte read: the read re-arms the flag
		if (hit_at(rd_hit, io_req.ofs, `SADC_OFS_RESULT_LOW)) begin
			s_next.pending = 1'b1;
		end
		// Outputs are registered copies of the next state
		s_next.mux = s_next.channel;
		s_next.gain_oh = gain_decode(s_next.gain);
		s_next.busy = (s_next.st != sadc_pkg::SADC_IDLE);
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_reg <= RESET_STATE;
		end else if (clk_en) begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign io_rdata = s_reg.rdata;
	assign mux_channel = s_reg.mux;
	assign gain_onehot = s_reg.gain_oh;
	assign conv_start = s_reg.start;
	assign conv_busy = s_reg.busy;

endmodule

// >>> shared/sadc_defs.svh
/*
 * Register offsets, field positions and timing counts of the software-triggered converter port.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

`define SADC_OFS_RESULT_LOW 4'h4
`define SADC_OFS_RESULT_HIGH 4'h5
`define SADC_OFS_GAIN_SELECT 4'h9
`define SADC_OFS_CHANNEL_SELECT 4'ha
`define SADC_OFS_CONV_TRIGGER 4'hc
`define SADC_PENDING_BIT 4
`define SADC_CHANNEL_MSB 4
`define SADC_GAIN_MSB 2
`define SADC_RESET_CHANNEL 5'h00
`define SADC_RESET_GAIN 3'h0
`define SADC_RESET_GAIN_OH 5'h01
`define SADC_RESET_RESULT 12'h000
`define SADC_GAIN_X16_CODE 3'h4
`define SADC_CONV_TIME_NS 10000
`define SADC_CLK_PERIOD_NS 25
`define SADC_CONV_CYCLES ((`SADC_CONV_TIME_NS + `SADC_CLK_PERIOD_NS - 1) / `SADC_CLK_PERIOD_NS)

`endif

// >>> shared/sadc_pkg.sv
/*
 * Types of the software-triggered converter port.
 * Assumes the defs header is on the include path.
 */
`include "sadc_defs.svh"

package sadc_pkg;

	// One host I/O access
	typedef struct packed {
		logic rd;
		logic wr;
		logic [3:0] ofs;
		logic [7:0] wdata;
	} sadc_io_req_t;

	// Converter sequencing
	typedef enum logic [2:0] {
		SADC_IDLE = 3'b001,
		SADC_START = 3'b010,
		SADC_BUSY = 3'b100
	} sadc_state_t;

	// Gain one-hot x1,x2,x4,x8,x16
	typedef logic [4:0] sadc_gain_t;

endpackage

// >>> testbench/sadc_port_asserts.sv
/* Port checker for sadc_port.
   Assumes clk_en stays high while a conversion runs. */
`timescale 1ns/100ps
module sadc_port_asserts #(parameter int CONV_CYCLES = 400) (
	input wire logic core_clk, rst, clk_en, io_sel, conv_done, conv_start, conv_busy,
	input wire sadc_pkg::sadc_io_req_t io_req,
	input wire logic [7:0] io_rdata,
	input wire logic [11:0] conv_data,
	input wire logic [4:0] mux_channel,
	input wire sadc_pkg::sadc_gain_t gain_onehot
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	localparam int BUSY_MAX = CONV_CYCLES + 3;
	logic wr_go, rd_go;
	assign wr_go = clk_en && io_sel && io_req.wr;
	assign rd_go = clk_en && io_sel && io_req.rd;
	////////////////////////////////////////////////////////////////
	a_unused_read_zero: assert property (rd_go && io_req.ofs != 4'h4 && io_req.ofs != 4'h5
		|=> io_rdata == 8'h00) else $error("unused read not zero");
	a_high_top_zero: assert property (rd_go && io_req.ofs == 4'h5 |=> io_rdata[7:5] == 3'h0)
		else $error("high byte top bits set");
	a_trigger_starts: assert property (wr_go && io_req.ofs == 4'hc && !conv_busy
		|=> conv_start && conv_busy) else $error("trigger did not start");
	a_start_one_cycle: assert property (conv_start && clk_en |=> !conv_start)
		else $error("start pulse too long");
	a_start_cause: assert property ($rose(conv_start) |-> $past(wr_go && io_req.ofs == 4'hc))
		else $error("start without trigger");
	a_channel_load: assert property (wr_go && io_req.ofs == 4'ha
		|=> mux_channel == $past(io_req.wdata[4:0])) else $error("channel not loaded");
	a_gain_load: assert property (wr_go && io_req.ofs == 4'h9 |=> gain_onehot ==
		($past(io_req.wdata[2]) ? 5'h10 : 5'h01 << $past(io_req.wdata[1:0]))) else $error("bad gain");
	a_busy_bounded: assert property ($rose(conv_start) |-> ##[1:BUSY_MAX] !conv_busy)
		else $error("busy too long");
	a_rdata_one_cycle: assert property (clk_en && !rd_go |=> io_rdata == 8'h00)
		else $error("read data outlived its cycle");
	a_pending_rearm: assert property ((rd_go && io_req.ofs == 4'h4 && !conv_busy) ##2
		(rd_go && io_req.ofs == 4'h5) |=> io_rdata[4]) else $error("pending not re-armed");
	a_busy_needs_trigger: assert property (!conv_busy && !(wr_go && io_req.ofs == 4'hc)
		|=> !conv_busy) else $error("busy without trigger");
	cover property ((rd_go && io_req.ofs == 4'h5) ##1 !io_rdata[4]);
	cover property (wr_go && io_req.ofs == 4'hc);
	cover property (conv_done && conv_busy);
	cover property (rd_go && io_req.ofs == 4'h4);
endmodule
bind sadc_port sadc_port_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.core_clk(core_clk),
	.rst(rst), .clk_en(clk_en), .io_sel(io_sel), .conv_done(conv_done), .conv_start(conv_start),
	.conv_busy(conv_busy), .io_req(io_req), .io_rdata(io_rdata), .conv_data(conv_data),
	.mux_channel(mux_channel), .gain_onehot(gain_onehot));

// >>> testbench/sadc_conv_model.sv
/* Converter model: answers a start pulse with done and data a few cycles later.
   Assumes the design's core_clk and rst. */
`timescale 1ns/100ps
module sadc_conv_model (
	input wire logic core_clk, rst, conv_start,
	input wire logic [4:0] mux_channel,
	output logic conv_done,
	output logic [11:0] conv_data
);
	logic [2:0] cnt_reg;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 3'h0;
			conv_done <= 1'b0;
			conv_data <= 12'h000;
		end else begin
			conv_done <= cnt_reg == 3'h1;
			// Data toggles while not valid
			conv_data <= (cnt_reg == 3'h1) ? {mux_channel, 7'h2b} : ~conv_data;
			cnt_reg <= conv_start ? 3'h3 : (cnt_reg != 3'h0) ? cnt_reg - 3'h1 : 3'h0;
		end
	end
endmodule

// >>> testbench/test_sadc_port.sv
/* Bench for sadc_port acting as the host.
   Assumes the converter model on the far side. */
`timescale 1ns/100ps
module test_sadc_port;
	logic core_clk = 0, rst = 1, clk_en = 1, io_sel = 0, conv_done, conv_start, conv_busy;
	sadc_pkg::sadc_io_req_t io_req = '0;
	logic [7:0] io_rdata, rd_val;
	logic [11:0] conv_data;
	logic [4:0] mux_channel;
	sadc_pkg::sadc_gain_t gain_onehot;
	int num_errors = 0, tests_run = 0;
	always #12.5 core_clk = ~core_clk;
	sadc_port #(.CONV_CYCLES(8)) dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
		.io_req(io_req), .io_sel(io_sel), .io_rdata(io_rdata), .conv_done(conv_done),
		.conv_data(conv_data), .mux_channel(mux_channel), .gain_onehot(gain_onehot),
		.conv_start(conv_start), .conv_busy(conv_busy));
	sadc_conv_model model (.core_clk(core_clk), .rst(rst), .conv_start(conv_start),
		.mux_channel(mux_channel), .conv_done(conv_done), .conv_data(conv_data));
	task chk(input string n, input logic [11:0] s, e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task finish_test;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task io(input logic r, input logic [3:0] o, input logic [7:0] d);
		@(posedge core_clk);
		io_req <= '{r, !r, o, d};
		io_sel <= 1'b1;
		@(posedge core_clk);
		io_req <= '0;
		io_sel <= 1'b0;
		#1 rd_val = io_rdata;
	endtask
	task t_unused;
		for (int o = 0; o < 16; o++) if (o != 4 && o != 5) begin
			io(1'b1, o[3:0], 8'h00);
			chk("unused", rd_val, 8'h00);
		end
	endtask
	task t_gain;
		for (int g = 0; g < 8; g++) begin
			io(1'b0, 4'h9, {5'h1f, g[2:0]});
			chk("gain", gain_onehot, (g > 4) ? 5'h10 : 5'h01 << g);
		end
	endtask
	task t_desel;
		@(posedge core_clk);
		io_req <= '{1'b0, 1'b1, 4'ha, 8'h07};
		@(posedge core_clk);
		io_req <= '{1'b1, 1'b0, 4'h5, 8'h00};
		@(posedge core_clk);
		io_req <= '0;
		#1 chk("desel chan", mux_channel, 5'h00);
		chk("desel read", io_rdata, 8'h00);
	endtask
	task t_reset;
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		io(1'b1, 4'h5, 8'h00);
		chk("rst pend", rd_val, 8'h10);
		chk("rst chan", mux_channel, 5'h00);
		chk("rst gain", gain_onehot, 5'h01);
	endtask
	task t_convert;
		int i;
		io(1'b0, 4'ha, 8'hff);
		chk("chan", mux_channel, 5'h1f);
		io(1'b0, 4'hc, 8'h5a);
		for (i = 0; i < 40; i++) begin
			io(1'b1, 4'h5, 8'h00);
			if (rd_val[4] === 1'b0) break;
		end
		if (i == 40) begin
			num_errors++;
			finish_test;
		end
		chk("high", rd_val, 8'h0f);
		io(1'b0, 4'h4, 8'h00);
		io(1'b1, 4'h4, 8'h00);
		chk("low", rd_val, 8'hab);
		io(1'b1, 4'h5, 8'h00);
		chk("rearm", rd_val, 8'h1f);
		@(posedge core_clk);
		clk_en <= 1'b0;
		io(1'b0, 4'ha, 8'h03);
		@(posedge core_clk);
		clk_en <= 1'b1;
		#1 chk("frozen", mux_channel, 5'h1f);
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		io(1'b1, 4'h5, 8'h00);
		chk("reset pend", rd_val, 8'h10);
		chk("reset chan", mux_channel, 5'h00);
		chk("reset gain", gain_onehot, 5'h01);
		t_unused;
		t_gain;
		t_desel;
		t_convert;
		t_reset;
		finish_test;
	end
endmodule
